// >>> core/bic_map.vh
// offsets, field positions, reset value and command write mask for the bridge id/command regs
`ifndef BIC_MAP_VH
`define BIC_MAP_VH
`define BIC_OFF_VENDOR 8'h00
`define BIC_OFF_DEVICE 8'h02
`define BIC_OFF_CMD 8'h04
`define BIC_CMD_RESET 16'h0000
`define BIC_CMD_IRQ_DIS_BIT 10
`define BIC_CMD_FAST_B2B_ENABLE_BIT 9
`define BIC_CMD_SERR_EN_BIT 8
`define BIC_CMD_RESV7_BIT 7
`define BIC_CMD_WMASK 16'h0500
`define BIC_DCTL_NONFATAL_BIT 1
`define BIC_DCTL_FATAL_BIT 2
`endif

// >>> core/bic_irq_gate.v
// legacy interrupt-message gate: assert/deassert messages for the function's own pme interrupt
`timescale 1ns/1ps
module bic_irq_gate (
  input wire ref_clk,
  input wire rst,
  input wire pme_irq_level,
  input wire irq_msg_disable,
  output reg assert_msg,
  output reg deassert_msg,
  output reg inta_active
);
  reg want;

  // wanted level follows the pme request unless messages are disabled
  always @* begin
    want = pme_irq_level & ~irq_msg_disable; // RULE3
  end

  // edge of the wanted level sends one message; disabling drops an active interrupt
  always @(posedge ref_clk) begin
    if (rst) begin
      assert_msg <= 1'b0;
      deassert_msg <= 1'b0;
      inta_active <= 1'b0;
    end else begin
      assert_msg <= want & ~inta_active;
      deassert_msg <= ~want & inta_active; // RULE4
      inta_active <= want;
    end
  end
endmodule

// >>> core/bic_regs.v
// bridge identification and command registers with interrupt and serr message control
// Operation
// RULE1 - vendor code reads as fixed 16-bit value at offset 0
// RULE2 - device code reads as three fixed fields at offset 2
// RULE3 - irq-disable clear lets the function send legacy interrupt messages
// RULE4 - irq-disable set stops messages and deasserts an active interrupt
// RULE5 - irq-disable gates only own pme interrupt; forwarded messages pass
// RULE6 - fast back-to-back bit 9 always reads zero
// RULE7 - serr enable clear: serr only for device-control enabled conditions
// RULE8 - serr enable set: serr for primary-side errors, not secondary-side ones
// RULE9 - errors reported when serr enable or matching device-control enable set
// RULE10 - each sent serr message is flagged for the status register
// RULE11 - command resets to zero; reserved bits read-only
// RULE12 - writes to read-only or reserved bits are ignored
`timescale 1ns/1ps
`include "bic_map.vh"
module bic_regs #(
  parameter [15:0] VENDOR_CODE = 16'h1234, // arbitrary value
  parameter [7:0] DEVICE_UPPER = 8'h5a, // arbitrary value
  parameter [3:0] DEVICE_HIGH_NIBBLE = 4'h3, // arbitrary value
  parameter [3:0] DEVICE_LOW_NIBBLE = 4'h1 // arbitrary value
) (
  input wire ref_clk,
  input wire rst,
  input wire cfg_wr,
  input wire cfg_rd,
  input wire [7:0] cfg_addr,
  input wire [15:0] cfg_wdata,
  input wire [1:0] cfg_be,
  output reg [15:0] cfg_rdata,
  output reg cfg_rvalid,
  input wire [15:0] dev_ctl,
  input wire pme_irq_level,
  input wire fwd_msg_valid,
  input wire [7:0] fwd_msg,
  output reg up_msg_valid,
  output reg [7:0] up_msg,
  output reg inta_assert_msg,
  output reg inta_deassert_msg,
  input wire err_primary_nonfatal,
  input wire err_primary_fatal,
  input wire err_secondary,
  output reg serr_msg,
  output reg serr_signaled,
  output reg [15:0] bridge_command
);
  localparam CMD_W = 16;

  // command register state
  reg [CMD_W-1:0] cmd_reg;

  // merged next value of the command register
  wire [CMD_W-1:0] cmd_next;

  // command word as software sees it
  wire [CMD_W-1:0] cmd_view;

  // read mux output, captured on the read strobe
  reg [15:0] rd_next;

  // assembled identity words
  wire [15:0] vendor_code;
  wire [15:0] device_code;

  // identity fields
  wire [7:0] device_code_upper_byte;
  wire [3:0] device_code_high_nibble;
  wire [3:0] device_code_low_nibble;

  // interrupt-message disable view
  wire legacy_irq_msg_disable;

  // unimplemented fast back-to-back view
  wire fast_b2b_enable;

  // system-error message enable view
  wire system_error_msg_enable;

  // enables from the device-control word
  wire nf_en;
  wire f_en;

  // identity offset hits
  wire hit_vendor;
  wire hit_device;

  // command offset hit and accepted write
  wire hit_cmd;
  wire cmd_wr;

  // writable positions
  wire [CMD_W-1:0] wr_mask;

  // lanes opened by the byte enables
  wire [CMD_W-1:0] byte_sel;

  // per-bit write enable
  wire [CMD_W-1:0] bit_we;

  // per-class error reports
  wire nf_report;
  wire f_report;

  // any qualified error this cycle
  wire serr_fire;

  // own interrupt gate outputs
  wire g_assert;
  wire g_deassert;

  genvar gi;

  // upper identity field; parameters only, so no write can reach it
  assign device_code_upper_byte = DEVICE_UPPER; // RULE2

  // middle identity field
  assign device_code_high_nibble = DEVICE_HIGH_NIBBLE; // RULE2

  // low identity field
  assign device_code_low_nibble = DEVICE_LOW_NIBBLE; // RULE2

  // vendor word
  assign vendor_code = VENDOR_CODE; // RULE1

  // device word from its three fields
  assign device_code = {device_code_upper_byte, device_code_high_nibble,
    device_code_low_nibble}; // RULE2

  // interrupt-message disable bit
  assign legacy_irq_msg_disable = cmd_reg[`BIC_CMD_IRQ_DIS_BIT];

  // fast back-to-back is not implemented
  assign fast_b2b_enable = 1'b0; // RULE6

  // system-error message enable bit
  assign system_error_msg_enable = cmd_reg[`BIC_CMD_SERR_EN_BIT];

  // non-fatal reporting enable
  assign nf_en = dev_ctl[`BIC_DCTL_NONFATAL_BIT];

  // fatal reporting enable
  assign f_en = dev_ctl[`BIC_DCTL_FATAL_BIT];

  // identity offsets; full byte compare so aliases never hit
  assign hit_vendor = (cfg_addr == `BIC_OFF_VENDOR);
  assign hit_device = (cfg_addr == `BIC_OFF_DEVICE);

  // command offset; writes elsewhere are dropped
  assign hit_cmd = (cfg_addr == `BIC_OFF_CMD);
  assign cmd_wr = cfg_wr & hit_cmd; // RULE12

  // only bits 10 and 8 are writable
  assign wr_mask = `BIC_CMD_WMASK; // RULE11

  // byte lanes; low lane opens nothing writable
  assign byte_sel = {{8{cfg_be[1]}}, {8{cfg_be[0]}}};

  // a bit is written only when writable, its lane open and the offset hit
  assign bit_we = wr_mask & byte_sel & {CMD_W{cmd_wr}}; // RULE12

  // per-bit merge; read-only bits are forced back to zero
  generate
    for (gi = 0; gi < CMD_W; gi = gi + 1) begin : g_cmd_bit
      assign cmd_next[gi] = bit_we[gi] ? cfg_wdata[gi] :
        (cmd_reg[gi] & wr_mask[gi]); // RULE12
    end
  endgenerate

  // command register, zero after reset
  always @(posedge ref_clk) begin
    if (rst) begin
      cmd_reg <= `BIC_CMD_RESET; // RULE11
    end else begin
      cmd_reg <= cmd_next; // RULE11
    end
  end

  // visible command word; all but bits 10 and 8 hardwired to zero
  assign cmd_view = {5'h00, legacy_irq_msg_disable, fast_b2b_enable,
    system_error_msg_enable, 8'h00}; // RULE6 RULE11

  // read mux; unmapped offsets return zero rather than stale data
  always @* begin
    rd_next = 16'h0000;
    if (hit_vendor) begin
      rd_next = vendor_code; // RULE1
    end else if (hit_device) begin
      rd_next = device_code; // RULE2
    end else if (hit_cmd) begin
      rd_next = cmd_view; // RULE6
    end
  end

  // read answer strobe, one cycle after the request
  always @(posedge ref_clk) begin
    if (rst) begin
      cfg_rvalid <= 1'b0;
    end else begin
      cfg_rvalid <= cfg_rd;
    end
  end

  // read data holds until the next read so software may take it late
  always @(posedge ref_clk) begin
    if (rst) begin
      cfg_rdata <= 16'h0000;
    end else if (cfg_rd) begin
      cfg_rdata <= rd_next;
    end
  end

  // own interrupt gate; forwarded traffic does not pass through it
  bic_irq_gate u_gate (
    .ref_clk(ref_clk),
    .rst(rst),
    .pme_irq_level(pme_irq_level),
    .irq_msg_disable(legacy_irq_msg_disable),
    .assert_msg(g_assert),
    .deassert_msg(g_deassert),
    .inta_active()
  );

  // non-fatal primary error with either enable
  assign nf_report = err_primary_nonfatal & (system_error_msg_enable | nf_en); // RULE7 RULE9

  // fatal primary error with either enable
  assign f_report = err_primary_fatal & (system_error_msg_enable | f_en); // RULE7 RULE9

  // err_secondary is deliberately no source: secondary-side errors are excluded
  assign serr_fire = nf_report | f_report; // RULE8

  // forwarded message valid passes regardless of the disable bit
  always @(posedge ref_clk) begin
    if (rst) begin
      up_msg_valid <= 1'b0;
    end else begin
      up_msg_valid <= fwd_msg_valid; // RULE5
    end
  end

  // forwarded message payload, copied one cycle late
  always @(posedge ref_clk) begin
    if (rst) begin
      up_msg <= 8'h00;
    end else begin
      up_msg <= fwd_msg; // RULE5
    end
  end

  // own interrupt assert message
  always @(posedge ref_clk) begin
    if (rst) begin
      inta_assert_msg <= 1'b0;
    end else begin
      inta_assert_msg <= g_assert; // RULE3
    end
  end

  // own interrupt deassert message
  always @(posedge ref_clk) begin
    if (rst) begin
      inta_deassert_msg <= 1'b0;
    end else begin
      inta_deassert_msg <= g_deassert; // RULE4
    end
  end

  // system-error message pulse
  always @(posedge ref_clk) begin
    if (rst) begin
      serr_msg <= 1'b0;
    end else begin
      serr_msg <= serr_fire; // RULE8
    end
  end

  // event flag for the status register, same cycle as the message
  always @(posedge ref_clk) begin
    if (rst) begin
      serr_signaled <= 1'b0;
    end else begin
      serr_signaled <= serr_fire; // RULE10
    end
  end

  // registered copy of the command word, same edge as the register itself
  always @(posedge ref_clk) begin
    if (rst) begin
      bridge_command <= `BIC_CMD_RESET;
    end else begin
      bridge_command <= cmd_next; // RULE11
    end
  end

  // fixed identity words are never registered; they cannot change at run time
endmodule

// >>> test/bic_fwd_src.sv
// upstream source of forwarded messages
`timescale 1ns/1ps
module bic_fwd_src (
  input wire ref_clk,
  input wire rst,
  output reg fwd_msg_valid = 1'b0,
  output reg [7:0] fwd_msg = 8'h00
);
  // idle data keeps changing so a stale copy cannot pass
  always @(posedge ref_clk) begin
    #1;
    fwd_msg_valid = !rst && $urandom;
    fwd_msg = $urandom;
  end
endmodule

// >>> test/bic_regs_props.sv
// assertions on the bridge id/command register ports
`timescale 1ns/1ps
module bic_regs_props (
  input wire ref_clk,
  input wire rst,
  input wire cfg_rd,
  input wire cfg_rvalid,
  input wire [15:0] dev_ctl,
  input wire fwd_msg_valid,
  input wire [7:0] fwd_msg,
  input wire up_msg_valid,
  input wire [7:0] up_msg,
  input wire inta_assert_msg,
  input wire err_primary_nonfatal,
  input wire err_primary_fatal,
  input wire err_secondary,
  input wire serr_msg,
  input wire serr_signaled,
  input wire [15:0] bridge_command
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  chk_read_answer: assert property (cfg_rd |=> cfg_rvalid) else $error("no read answer");
  chk_fast_b2b_enable_zero: assert property (!bridge_command[9]) else $error("bit 9 set");
  chk_cmd_mask: assert property ((bridge_command & 16'hfaff) == 0)
    else $error("read-only command bit set");
  chk_fwd_pass: assert property (fwd_msg_valid |=> up_msg_valid && up_msg == $past(fwd_msg))
    else $error("forwarded message lost");
  chk_irq_quiet: assert property (bridge_command[10] [*3] |=> !inta_assert_msg)
    else $error("assert while disabled");
  chk_sec_quiet: assert property (err_secondary && !err_primary_nonfatal && !err_primary_fatal
    |=> !serr_msg) else $error("serr for secondary error");
  chk_serr_gated: assert property (!bridge_command[8] && dev_ctl[2:1] == 0 |=> !serr_msg)
    else $error("serr while not enabled");
  chk_serr_fires: assert property (err_primary_fatal && (bridge_command[8] || dev_ctl[2])
    |=> serr_msg && serr_signaled) else $error("fatal error not reported");
  chk_serr_status: assert property (serr_msg |-> serr_signaled) else $error("serr not flagged");
endmodule

// >>> test/bic_regs_tb_top.sv
// self-checking bench for the bridge id/command registers
`timescale 1ns/1ps
module bic_regs_tb_top;
  reg ref_clk = 0, rst = 1, cfg_wr = 0, cfg_rd = 0, pme_irq_level = 0;
  reg err_primary_nonfatal = 0, err_primary_fatal = 0, err_secondary = 0;
  reg [7:0] cfg_addr = 0;
  reg [15:0] cfg_wdata = 0, dev_ctl = 0, d, n_as = 0, n_de = 0, n_se = 0;
  reg [1:0] cfg_be = 0;
  wire [15:0] cfg_rdata, bridge_command;
  wire [7:0] fwd_msg, up_msg;
  wire cfg_rvalid, fwd_msg_valid, up_msg_valid, inta_assert_msg, inta_deassert_msg;
  wire serr_msg, serr_signaled;
  integer failures = 0, n_checks = 0, cyc = 0, i;
  bic_regs dut_u (.*);
  bic_fwd_src src_u (.*);
  initial forever #2.5 ref_clk = !ref_clk;
  task results;
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task cmp(input [15:0] got, input [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task tick;
    @(posedge ref_clk);
    #1;
  endtask
  task wr(input [7:0] a, input [15:0] v, input [1:0] b);
    cfg_addr = a;
    cfg_wdata = v;
    cfg_be = b;
    cfg_wr = 1;
    tick;
    cfg_wr = 0;
  endtask
  task rd(input [7:0] a, input [15:0] e);
    cfg_addr = a;
    cfg_rd = 1;
    tick;
    cfg_rd = 0;
    cmp(cfg_rvalid, 1);
    cmp(cfg_rdata, e);
  endtask
  // pulse counters; the cycle ceiling cuts a hang short
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    n_as <= n_as + inta_assert_msg;
    n_de <= n_de + inta_deassert_msg;
    n_se <= n_se + serr_msg;
    if (cyc == 2000) begin
      failures++;
      results;
    end
  end
  initial begin
    void'($urandom(32'h0487b3aa));
    repeat (5) tick;
    rst = 0;
    rd(8'h00, 16'h1234);
    rd(8'h02, 16'h5a31);
    rd(8'h04, 16'h0000);
    wr(8'h00, 16'hffff, 2'b11);
    rd(8'h00, 16'h1234);
    wr(8'h04, 16'hffff, 2'b01);
    rd(8'h04, 16'h0000);
    rd(8'h10, 16'h0000);
    for (i = 0; i < 16; i++) begin
      d = $urandom;
      dev_ctl = $urandom;
      wr(8'h04, d, 2'b11);
      rd(8'h04, d & 16'h0500);
    end
    dev_ctl = 0;
    wr(8'h04, 16'h0000, 2'b11);
    pme_irq_level = 1;
    repeat (6) tick;
    cmp(n_as, 1);
    wr(8'h04, 16'h0400, 2'b11);
    repeat (5) tick;
    cmp(n_de, 1);
    pme_irq_level = 0;
    err_secondary = 1;
    tick;
    err_secondary = 0;
    err_primary_fatal = 1;
    tick;
    err_primary_fatal = 0;
    repeat (2) tick;
    cmp(n_se, 0);
    wr(8'h04, 16'h0100, 2'b11);
    err_primary_nonfatal = 1;
    tick;
    err_primary_nonfatal = 0;
    repeat (2) tick;
    cmp(n_se, 1);
    wr(8'h04, 16'h0000, 2'b11);
    dev_ctl = 16'h0004;
    err_primary_fatal = 1;
    tick;
    err_primary_fatal = 0;
    repeat (2) tick;
    cmp(n_se, 2);
    results;
  end
endmodule
bind bic_regs bic_regs_props chk_u (.*);
